/* File: shared/eac_pkg.sv */
// shared constants, types and register map of the nvm access control block
package eac_pkg;

   // ------------------------------------------------------------
   // register map and io port
   // ------------------------------------------------------------
   localparam int          IO_AW       = 6;
   localparam logic [5:0]  OFS_CONTROL = 6'h1C;  // nvm_control_reg
   localparam logic [5:0]  OFS_DATA    = 6'h1D;  // nvm_data_reg
   localparam logic [5:0]  OFS_ADDRESS = 6'h1E;  // nvm_address_reg

   // control register bit positions
   localparam int BIT_READ_STROBE = 0;
   localparam int BIT_PROG_EN     = 1;
   localparam int BIT_MASTER_EN   = 2;
   localparam int BIT_RDY_IRQ_EN  = 3;
   localparam int BIT_MODE_LO     = 4;
   localparam int BIT_MODE_HI     = 5;
   localparam int BIT_RSVD_LO     = 6;
   localparam int BIT_RSVD_HI     = 7;

   // reset values
   localparam logic [7:0] DATA_RST  = 8'h00;
   localparam logic [7:0] ADDR_RST  = 8'h00;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [7:0] ERASED    = 8'hFF;

   // ------------------------------------------------------------
   // memory array geometry
   // ------------------------------------------------------------
   localparam int MEM_AW    = 8;
   localparam int MEM_DEPTH = 256;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int T_ATOMIC_NS   = 3400000;  // 3.4 ms
   localparam int T_SPLIT_NS    = 1800000;  // 1.8 ms
   localparam int ATOMIC_CYC    =
      (T_ATOMIC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SPLIT_CYC     =
      (T_SPLIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W         = 18;

   localparam logic [2:0] MASTER_WIN_CYC = 3'h4;  // master enable life
   localparam logic [2:0] PROG_STALL_CYC = 3'h2;  // cpu halt on start
   localparam logic [2:0] READ_STALL_CYC = 3'h4;  // cpu halt on read
   localparam logic [2:0] CNT3_ZERO      = 3'h0;
   localparam logic [2:0] CNT3_ONE       = 3'h1;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      EAC_MODE_ATOMIC = 2'b00,
      EAC_MODE_ERASE  = 2'b01,
      EAC_MODE_WRITE  = 2'b10,
      EAC_MODE_RSVD   = 2'b11
   } eac_mode_t;

   typedef enum logic [1:0] {
      EAC_ST_IDLE = 2'b00,
      EAC_ST_PROG = 2'b01
   } eac_state_t;

   // one cpu io access
   typedef struct packed {
      logic             wr;     // write strobe
      logic             rd;     // read strobe
      logic [IO_AW-1:0] addr;   // io address
      logic [7:0]       wdata;  // write data
   } eac_io_req_t;

   // one memory programming command
   typedef struct packed {
      logic              en;
      eac_mode_t         op;
      logic [MEM_AW-1:0] addr;
      logic [7:0]        data;
   } eac_prog_t;

endpackage

/* File: design/eac_nvm_array.sv */
// byte-wide non-volatile array model with registered read data
module eac_nvm_array (
   input  wire logic                       core_clk,
   input  wire logic                       rst,
   input  wire logic                       rd_en,
   input  wire logic [eac_pkg::MEM_AW-1:0] rd_addr,
   output logic      [7:0]                 rd_data,
   input  wire eac_pkg::eac_prog_t         prog
);

   logic [7:0] mem_r [eac_pkg::MEM_DEPTH];
   logic [7:0] old_byte;
   logic [7:0] new_byte;
   logic [7:0] rd_data_r;
   logic [7:0] rd_data_nxt;

   // ------------------------------------------------------------
   // programming: erase sets bits, write only clears bits
   // ------------------------------------------------------------
   always_comb begin
      old_byte = mem_r[prog.addr];
      case (prog.op)
         eac_pkg::EAC_MODE_ATOMIC : new_byte = prog.data;
         eac_pkg::EAC_MODE_ERASE  : new_byte = eac_pkg::ERASED;
         eac_pkg::EAC_MODE_WRITE  : new_byte = old_byte & prog.data;
         default                  : new_byte = old_byte;
      endcase
   end

   // array cells hold their contents across reset
   always_ff @(posedge core_clk) begin
      if (prog.en) begin
         mem_r[prog.addr] <= new_byte;
      end
   end

   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   always_comb begin
      rd_data_nxt = rd_en ? mem_r[rd_addr] : rd_data_r;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rd_data_r <= eac_pkg::ZERO_BYTE;
      end else begin
         rd_data_r <= rd_data_nxt;
      end
   end

   assign rd_data = rd_data_r;

endmodule // eac_nvm_array

/* File: design/eac_access_ctrl.sv */
// register-level control of the on-chip nvm: registers, timing, interlocks
// Functional notes
// - write mode programs data byte at address
// - read loads data register from addressed byte
// - mode field picks atomic, erase, write, reserved
// - program enable performs selected mode action
// - mode writes ignored while program enable set
// - reset clears mode unless programming busy
// - ready irq needs enable bit and global enable
// - ready irq is level while not busy
// - program start only within master enable window
// - program enable ignored without master enable
// - master enable self-clears after four cycles
// - program enable held until programming time elapses
// - program start stalls cpu two cycles
// - read completes within one instruction
// - read stalls cpu four cycles
// - busy blocks reads and address changes
// - control bits seven and six read zero
// - busy refuses any other memory operation
module eac_access_ctrl #(
   parameter int unsigned ATOMIC_CYC = eac_pkg::ATOMIC_CYC,
   parameter int unsigned SPLIT_CYC  = eac_pkg::SPLIT_CYC
) (
   input  wire logic                 core_clk,
   input  wire logic                 rst,
   input  wire logic                 por,
   input  wire eac_pkg::eac_io_req_t io_req,
   output logic      [7:0]           io_rdata,
   input  wire logic                 global_irq_en,
   output logic                      ready_irq,
   output logic                      cpu_stall
);

   localparam logic [eac_pkg::CNT_W-1:0] ATOMIC_TC =
      eac_pkg::CNT_W'(ATOMIC_CYC);
   localparam logic [eac_pkg::CNT_W-1:0] SPLIT_TC  =
      eac_pkg::CNT_W'(SPLIT_CYC);
   localparam logic [eac_pkg::CNT_W-1:0] CNT_ZERO  = '0;
   localparam logic [eac_pkg::CNT_W-1:0] CNT_ONE   =
      eac_pkg::CNT_W'(1);

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   logic wr_ctl;
   logic wr_data;
   logic wr_addr;
   logic rd_any;
   logic busy;
   logic start;
   logic rd_go;
   logic done;

   // io write strobes per register
   always_comb begin
      wr_ctl  = io_req.wr && (io_req.addr == eac_pkg::OFS_CONTROL);
      wr_data = io_req.wr && (io_req.addr == eac_pkg::OFS_DATA);
      wr_addr = io_req.wr && (io_req.addr == eac_pkg::OFS_ADDRESS);
      rd_any  = io_req.rd;
   end

   // ------------------------------------------------------------
   // master program enable window
   // ------------------------------------------------------------
   logic       master_r;
   logic       master_nxt;
   logic [2:0] master_cnt_r;
   logic [2:0] master_cnt_nxt;

   // a write of one opens a four cycle window, then it drops by itself
   always_comb begin
      master_nxt     = master_r;
      master_cnt_nxt = master_cnt_r;
      if (master_cnt_r == eac_pkg::CNT3_ONE) begin
         master_nxt     = 1'b0;
         master_cnt_nxt = eac_pkg::CNT3_ZERO;
      end else if (master_cnt_r != eac_pkg::CNT3_ZERO) begin
         master_cnt_nxt = master_cnt_r - eac_pkg::CNT3_ONE;
      end
      if (wr_ctl) begin
         if (io_req.wdata[eac_pkg::BIT_MASTER_EN]) begin
            master_nxt     = 1'b1;
            master_cnt_nxt = eac_pkg::MASTER_WIN_CYC;
         end else begin
            master_nxt     = 1'b0;
            master_cnt_nxt = eac_pkg::CNT3_ZERO;
         end
      end
      if (start) begin
         master_nxt     = 1'b0; // window used up by this start
         master_cnt_nxt = eac_pkg::CNT3_ZERO;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         master_r     <= 1'b0;
         master_cnt_r <= eac_pkg::CNT3_ZERO;
      end else begin
         master_r     <= master_nxt;
         master_cnt_r <= master_cnt_nxt;
      end
   end

   // ------------------------------------------------------------
   // software-visible control and data registers
   // ------------------------------------------------------------
   logic       rdy_ie_r;
   logic       rdy_ie_nxt;
   logic [7:0] data_r;
   logic [7:0] data_nxt;
   logic [7:0] addr_r;
   logic [7:0] addr_nxt;
   logic       rd_pend_r;
   logic       rd_pend_nxt;
   logic [7:0] mem_rdata;

   // interrupt enable, data and address registers
   always_comb begin
      rdy_ie_nxt  = rdy_ie_r;
      data_nxt    = data_r;
      addr_nxt    = addr_r;
      rd_pend_nxt = rd_go;
      if (wr_ctl) begin
         rdy_ie_nxt = io_req.wdata[eac_pkg::BIT_RDY_IRQ_EN];
      end
      if (wr_data) begin
         data_nxt = io_req.wdata;
      end
      if (rd_pend_r) begin
         data_nxt = mem_rdata;
      end
      if (wr_addr && !busy) begin
         addr_nxt = io_req.wdata;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdy_ie_r  <= 1'b0;
         data_r    <= eac_pkg::DATA_RST;
         addr_r    <= eac_pkg::ADDR_RST;
         rd_pend_r <= 1'b0;
      end else begin
         rdy_ie_r  <= rdy_ie_nxt;
         data_r    <= data_nxt;
         addr_r    <= addr_nxt;
         rd_pend_r <= rd_pend_nxt;
      end
   end

   // ------------------------------------------------------------
   // start and read qualification
   // ------------------------------------------------------------
   eac_pkg::eac_mode_t mode_r;
   eac_pkg::eac_mode_t mode_nxt;

   // a start needs an open master window and an idle engine
   always_comb begin
      start = wr_ctl && io_req.wdata[eac_pkg::BIT_PROG_EN] && master_r
              && !busy && (mode_r != eac_pkg::EAC_MODE_RSVD) && !rst;
      rd_go = wr_ctl && io_req.wdata[eac_pkg::BIT_READ_STROBE]
              && !busy && !start && !rst;
   end

   // ------------------------------------------------------------
   // programming mode field, kept through reset while busy
   // ------------------------------------------------------------
   // cleared asynchronously on power-on reset only; system reset acts on the clock
   always_comb begin
      mode_nxt = mode_r;
      if (rst) begin
         if (!busy) begin
            mode_nxt = eac_pkg::EAC_MODE_ATOMIC;
         end
      end else if (wr_ctl && !busy) begin
         mode_nxt = eac_pkg::eac_mode_t'(
            {io_req.wdata[eac_pkg::BIT_MODE_HI],
             io_req.wdata[eac_pkg::BIT_MODE_LO]});
      end
   end

   always_ff @(posedge core_clk or posedge por) begin
      if (por) begin
         mode_r <= eac_pkg::EAC_MODE_ATOMIC;
      end else begin
         mode_r <= mode_nxt;
      end
   end

   // ------------------------------------------------------------
   // programming engine, survives system reset
   // ------------------------------------------------------------
   eac_pkg::eac_state_t           state_r;
   eac_pkg::eac_state_t           state_nxt;
   logic [eac_pkg::CNT_W-1:0]     tmr_r;
   logic [eac_pkg::CNT_W-1:0]     tmr_nxt;
   eac_pkg::eac_prog_t            job_r;
   eac_pkg::eac_prog_t            job_nxt;
   eac_pkg::eac_prog_t            prog;

   // latch the job on start, count down the mode's time, then commit
   always_comb begin
      state_nxt = state_r;
      tmr_nxt   = tmr_r;
      job_nxt   = job_r;
      done      = 1'b0;
      case (state_r)
         eac_pkg::EAC_ST_IDLE : begin
            if (start) begin
               state_nxt    = eac_pkg::EAC_ST_PROG;
               job_nxt.en   = 1'b0;
               job_nxt.op   = mode_r;
               job_nxt.addr = addr_r;
               job_nxt.data = data_r;
               if (mode_r == eac_pkg::EAC_MODE_ATOMIC) begin
                  tmr_nxt = ATOMIC_TC;
               end else begin
                  tmr_nxt = SPLIT_TC;
               end
            end
         end
         eac_pkg::EAC_ST_PROG : begin
            if (tmr_r <= CNT_ONE) begin
               done      = 1'b1;
               state_nxt = eac_pkg::EAC_ST_IDLE;
               tmr_nxt   = CNT_ZERO;
            end else begin
               tmr_nxt = tmr_r - CNT_ONE;
            end
         end
         default : begin
            state_nxt = eac_pkg::EAC_ST_IDLE;
            tmr_nxt   = CNT_ZERO;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge por) begin
      if (por) begin
         state_r <= eac_pkg::EAC_ST_IDLE;
         tmr_r   <= CNT_ZERO;
         job_r   <= '0;
      end else begin
         state_r <= state_nxt;
         tmr_r   <= tmr_nxt;
         job_r   <= job_nxt;
      end
   end

   // program enable reads back as the engine's busy state
   assign busy = (state_r == eac_pkg::EAC_ST_PROG);

   // memory write fires in the last cycle of the programming time
   always_comb begin
      prog    = job_r;
      prog.en = done;
   end

   // ------------------------------------------------------------
   // cpu stall counter
   // ------------------------------------------------------------
   logic [2:0] stall_r;
   logic [2:0] stall_nxt;

   always_comb begin
      stall_nxt = stall_r;
      if (start) begin
         stall_nxt = eac_pkg::PROG_STALL_CYC;
      end else if (rd_go) begin
         stall_nxt = eac_pkg::READ_STALL_CYC;
      end else if (stall_r != eac_pkg::CNT3_ZERO) begin
         stall_nxt = stall_r - eac_pkg::CNT3_ONE;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         stall_r <= eac_pkg::CNT3_ZERO;
      end else begin
         stall_r <= stall_nxt;
      end
   end

   assign cpu_stall = (stall_r != eac_pkg::CNT3_ZERO);

   // ------------------------------------------------------------
   // ready interrupt
   // ------------------------------------------------------------
   // level request while idle, gated by both enables
   assign ready_irq = rdy_ie_r && global_irq_en && !busy;

   // ------------------------------------------------------------
   // io read-back
   // ------------------------------------------------------------
   logic [7:0] ctl_view;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;

   // control register image; read strobe always reads back as zero
   always_comb begin
      ctl_view                           = eac_pkg::ZERO_BYTE;
      ctl_view[eac_pkg::BIT_RSVD_HI]     = 1'b0;
      ctl_view[eac_pkg::BIT_RSVD_LO]     = 1'b0;
      ctl_view[eac_pkg::BIT_MODE_HI]     = mode_r[1];
      ctl_view[eac_pkg::BIT_MODE_LO]     = mode_r[0];
      ctl_view[eac_pkg::BIT_RDY_IRQ_EN]  = rdy_ie_r;
      ctl_view[eac_pkg::BIT_MASTER_EN]   = master_r;
      ctl_view[eac_pkg::BIT_PROG_EN]     = busy;
      ctl_view[eac_pkg::BIT_READ_STROBE] = 1'b0;
   end

   // registered read data, unmapped addresses read zero
   always_comb begin
      rdata_nxt = rdata_r;
      if (rd_any) begin
         case (io_req.addr)
            eac_pkg::OFS_CONTROL : rdata_nxt = ctl_view;
            eac_pkg::OFS_DATA    : rdata_nxt = data_r;
            eac_pkg::OFS_ADDRESS : rdata_nxt = addr_r;
            default              : rdata_nxt = eac_pkg::ZERO_BYTE;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdata_r <= eac_pkg::ZERO_BYTE;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign io_rdata = rdata_r;

   // ------------------------------------------------------------
   // memory array
   // ------------------------------------------------------------
   eac_nvm_array u_array (
      .core_clk (core_clk),
      .rst      (rst),
      .rd_en    (rd_go),
      .rd_addr  (addr_r),
      .rd_data  (mem_rdata),
      .prog     (prog)
   );

endmodule // eac_access_ctrl

/* File: verif/eac_access_ctrl_sva.sv */
// concurrent checks on the ports of the nvm access control block
module eac_access_ctrl_sva #(
   parameter int unsigned ATOMIC_CYC = 20,
   parameter int unsigned SPLIT_CYC  = 10
) (
   input wire logic                 core_clk,
   input wire logic                 rst,
   input wire logic                 por,
   input wire eac_pkg::eac_io_req_t io_req,
   input wire logic [7:0]           io_rdata,
   input wire logic                 global_irq_en,
   input wire logic                 ready_irq,
   input wire logic                 cpu_stall
);
   timeunit 1ns;
   timeprecision 100ps;
   logic        wr_ctl, rd_ctl, start, rd_trig, mwin, busy;
   logic [1:0]  md_r;
   logic [2:0]  mcnt_r, mcnt_nxt;
   logic        ie_r, ie_nxt;
   logic [31:0] bcnt_r, bcnt_nxt;
   // shadow of master window, irq enable and busy time
   always_comb begin
      wr_ctl = io_req.wr && io_req.addr == eac_pkg::OFS_CONTROL;
      rd_ctl = io_req.rd && io_req.addr == eac_pkg::OFS_CONTROL;
      mwin = mcnt_r != 3'h0;
      busy = bcnt_r != 32'h0;
      start = wr_ctl && io_req.wdata[1] && mwin && !busy
         && md_r != 2'b11;
      rd_trig = wr_ctl && io_req.wdata[0] && !io_req.wdata[1] && !busy;
      ie_nxt = wr_ctl ? io_req.wdata[3] : ie_r;
      mcnt_nxt = mwin ? mcnt_r - 3'h1 : 3'h0;
      if (start || (wr_ctl && !io_req.wdata[2])) begin
         mcnt_nxt = 3'h0;
      end else if (wr_ctl) begin
         mcnt_nxt = 3'h4;
      end
      bcnt_nxt = busy ? bcnt_r - 32'h1 : 32'h0;
      if (start) begin
         bcnt_nxt = md_r == 2'b00 ? ATOMIC_CYC : SPLIT_CYC;
      end
   end
   // registers cleared by system reset
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mcnt_r <= 3'h0;
         ie_r   <= 1'b0;
      end else begin
         mcnt_r <= mcnt_nxt;
         ie_r   <= ie_nxt;
      end
   end
   // busy time survives system reset, cleared by power-on only
   always_ff @(posedge core_clk or posedge por) begin
      if (por) begin
         bcnt_r <= 32'h0;
      end else begin
         bcnt_r <= bcnt_nxt;
      end
   end
   // mode field shadow: a start uses the stored mode, not the written one
   always_ff @(posedge core_clk or posedge por) begin
      if (por) begin
         md_r <= 2'b00;
      end else if (rst) begin
         md_r <= busy ? md_r : 2'b00;
      end else if (wr_ctl && !busy) begin
         md_r <= io_req.wdata[5:4];
      end
   end
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   a_irq_gated: assert property (ready_irq |-> global_irq_en && ie_r)
      else $error("ready irq without both enables");
   a_irq_level: assert property (!busy && ie_r && global_irq_en
      |-> ready_irq) else $error("ready irq missing while idle");
   a_busy_quiet: assert property (busy |-> !ready_irq)
      else $error("ready irq while programming");
   a_prog_stall: assert property (start && !cpu_stall
      |=> cpu_stall [*2] ##1 !cpu_stall) else $error("bad start stall");
   a_read_stall: assert property (rd_trig && !cpu_stall
      |=> cpu_stall [*4] ##1 !cpu_stall) else $error("bad read stall");
   a_no_master: assert property (wr_ctl && io_req.wdata[1] && !mwin
      && !io_req.wdata[0] && !cpu_stall |=> !cpu_stall [*2])
      else $error("start taken without master enable");
   a_rsvd_mode: assert property (wr_ctl && io_req.wdata[1] && mwin
      && md_r == 2'b11 && !io_req.wdata[0] && !busy && !cpu_stall
      |=> !cpu_stall [*3]) else $error("reserved mode started");
   a_rsvd_zero: assert property (rd_ctl
      |=> io_rdata[7:6] == 2'b00 && !io_rdata[0])
      else $error("control reserved bits not zero");
   a_master_life: assert property (rd_ctl
      |=> io_rdata[2] == $past(mwin)) else $error("master bit wrong");
   a_busy_bit: assert property (rd_ctl
      |=> io_rdata[1] == $past(busy)) else $error("busy bit wrong");
   c_start: cover property (start);
   c_read: cover property (rd_trig);
   c_irq: cover property ($rose(ready_irq));
endmodule // eac_access_ctrl_sva

bind eac_access_ctrl eac_access_ctrl_sva #(
   .ATOMIC_CYC(ATOMIC_CYC),
   .SPLIT_CYC (SPLIT_CYC)
) u_sva (
   .core_clk     (core_clk),
   .rst          (rst),
   .por          (por),
   .io_req       (io_req),
   .io_rdata     (io_rdata),
   .global_irq_en(global_irq_en),
   .ready_irq    (ready_irq),
   .cpu_stall    (cpu_stall)
);

/* File: verif/eac_nvm_shadow.sv */
// shadow of the nvm byte array behind the control block
module eac_nvm_shadow;
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] mem [256];
   // apply one finished programming job
   task automatic program_byte(input logic [1:0] m, input logic [7:0] a,
                               input logic [7:0] d);
      case (m)
         2'b00: mem[a] = d;
         2'b01: mem[a] = eac_pkg::ERASED;
         2'b10: mem[a] = mem[a] & d;
         default: ;
      endcase
   endtask
endmodule // eac_nvm_shadow

/* File: verif/eac_access_ctrl_tb.sv */
// self-checking bench for the nvm access control block
module eac_access_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int unsigned ATOM = 30;
   localparam int unsigned SPLT = 16;
   localparam logic [5:0] CTL = eac_pkg::OFS_CONTROL;
   localparam logic [5:0] DAT = eac_pkg::OFS_DATA;
   localparam logic [5:0] ADR = eac_pkg::OFS_ADDRESS;
   logic                 core_clk = 1'b0;
   logic                 rst = 1'b1;
   logic                 por = 1'b1;
   eac_pkg::eac_io_req_t io_req = '0;
   logic                 global_irq_en = 1'b0;
   logic [7:0]           io_rdata;
   logic                 ready_irq;
   logic                 cpu_stall;
   int                   bad_count = 0;
   int                   n_checks = 0;
   int                   cycles = 0;
   logic                 ie_v = 1'b0;
   logic [7:0]           v, a, d;

   eac_nvm_shadow shadow ();
   eac_access_ctrl #(.ATOMIC_CYC(ATOM), .SPLIT_CYC(SPLT)) dut (
      .core_clk     (core_clk),
      .rst          (rst),
      .por          (por),
      .io_req       (io_req),
      .io_rdata     (io_rdata),
      .global_irq_en(global_irq_en),
      .ready_irq    (ready_irq),
      .cpu_stall    (cpu_stall)
   );
   // ------------------------------------------------------------
   // clock, hang guard and helpers
   // ------------------------------------------------------------
   always #12.5 core_clk = ~core_clk;
   // cut a hang short
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         bad_count++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one io cycle, launched at the falling edge
   task automatic op(input logic w, r, input logic [5:0] ad,
                     input logic [7:0] dt);
      @(negedge core_clk);
      io_req = '{wr: w, rd: r, addr: ad, wdata: dt};
   endtask
   task automatic wr(input logic [5:0] ad, input logic [7:0] dt);
      op(1'b1, 1'b0, ad, dt);
   endtask
   task automatic idle(input int n);
      repeat (n) op(1'b0, 1'b0, 6'h00, 8'h00);
   endtask
   task automatic rd(input logic [5:0] ad, output logic [7:0] q);
      op(1'b0, 1'b1, ad, 8'h00);
      idle(1);
      q = io_rdata;
   endtask
   // expected control byte
   function automatic logic [7:0] ctl(input logic [1:0] m,
                                      input logic mp, pe, re);
      return {2'b00, m, ie_v, mp, pe, re};
   endfunction
   // poll the busy bit, bounded
   task automatic wait_idle();
      int n = 0;
      rd(CTL, v);
      while (v[1] !== 1'b0 && n < 100) begin
         rd(CTL, v);
         n++;
      end
      check({7'h00, v[1]}, 8'h00);
   endtask
   // master then start after gap idle cycles; ok says it must start
   task automatic prog(input logic [1:0] m, input int gap, input logic ok);
      wr(CTL, ctl(m, 1'b1, 1'b0, 1'b0));
      idle(gap);
      wr(CTL, ctl(m, 1'b0, 1'b1, 1'b0));
      idle(3);
      rd(CTL, v);
      check(v, ctl(m, 1'b0, ok, 1'b0));
      if (ok) shadow.program_byte(m, a, d);
   endtask
   // trigger a read at address a and compare the data register
   task automatic check_mem();
      wr(CTL, ctl(2'b00, 1'b0, 1'b0, 1'b1));
      idle(1);
      check({7'h00, cpu_stall}, 8'h01);
      idle(3);
      rd(DAT, v);
      check(v, shadow.mem[a]);
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(59453));
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      rst = 1'b0;
      por = 1'b0;
      rd(CTL, v);
      check(v, 8'h00);
      rd(DAT, v);
      check(v, eac_pkg::DATA_RST);
      rd(6'h15, v);
      check(v, 8'h00);
      // data register read and write
      for (int i = 0; i < 4; i++) begin
         d = 8'($urandom());
         wr(DAT, d);
         rd(DAT, v);
         check(v, d);
      end
      // all three modes at one address, probing the busy locks
      global_irq_en = 1'b1;
      ie_v = 1'b1;
      a = 8'($urandom());
      wr(ADR, a);
      for (int m = 0; m < 3; m++) begin
         d = 8'($urandom());
         wr(DAT, d);
         prog(2'(m), 3 * (m % 2), 1'b1);
         check({7'h00, ready_irq}, 8'h00);
         wr(CTL, ctl(2'b11, 1'b0, 1'b0, 1'b0));
         wr(ADR, ~a);
         wr(CTL, ctl(2'(m), 1'b0, 1'b0, 1'b1));
         rd(CTL, v);
         check(v, ctl(2'(m), 1'b0, 1'b1, 1'b0));
         wait_idle();
         check({7'h00, ready_irq}, 8'h01);
         rd(ADR, v);
         check(v, a);
         rd(DAT, v);
         check(v, d);
         check_mem();
      end
      // refused starts: late, without master, reserved mode
      prog(2'b01, 4, 1'b0);
      wr(CTL, ctl(2'b01, 1'b0, 1'b1, 1'b0));
      idle(3);
      rd(CTL, v);
      check(v, ctl(2'b01, 1'b0, 1'b0, 1'b0));
      prog(2'b11, 0, 1'b0);
      check_mem();
      // ready irq under both enables
      for (int k = 0; k < 4; k++) begin
         ie_v = k[0];
         global_irq_en = k[1];
         wr(CTL, ctl(2'b00, 1'b0, 1'b0, 1'b0));
         idle(1);
         check({7'h00, ready_irq}, {7'h00, k[0] & k[1]});
      end
      // system reset in mid-programming keeps mode and finishes the job
      a = 8'($urandom());
      wr(ADR, a);
      prog(2'b01, 2, 1'b1);
      rst = 1'b1;
      ie_v = 1'b0; // system reset clears the irq enable
      idle(2);
      rst = 1'b0;
      rd(CTL, v);
      check(v, ctl(2'b01, 1'b0, 1'b1, 1'b0));
      wait_idle();
      wr(ADR, a);
      check_mem();
      // system reset while idle clears the mode field
      wr(CTL, ctl(2'b10, 1'b0, 1'b0, 1'b0));
      idle(1);
      rst = 1'b1;
      idle(2);
      rst = 1'b0;
      rd(CTL, v);
      check(v, 8'h00);
      print_verdict();
   end
endmodule // eac_access_ctrl_tb
